// ---- hdl/watchdog_mode_write_guard.sv ----
// Watchdog mode register write guard with APB slave, counter and deferred reset
// Function
// - A store to the mode configuration register stretches the bus access by one wait cycle.
// - With the non-stoppable oscillator option, other values of the top three bits are ignored.
// - One byte-wide mode write is accepted after reset; any later write attempt raises reset.
// - A forbidden write while the source clock is stopped raises reset only once it runs again.
// - With the software-stoppable option, the stop select bit halts the watchdog for good.
// - Stopping through the stop select bit raises no internal reset.
// - Any restart write other than a byte-wide key write raises reset, deferred while the clock is stopped.
// - Reading the restart register returns a fixed value unlike the key.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
module watchdog_mode_write_guard
    import wdt_guard_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        src_clk_running,
    input  wire logic        nonstop_option,
    output logic             wdt_reset
);

    // ------------------------------------------------------------
    // Input synchronisers and tick
    // ------------------------------------------------------------
    logic clk_run_s;
    logic nonstop_s;
    logic tick;

    level_sync u_run_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (src_clk_running),
        .q       (clk_run_s)
    );

    level_sync u_opt_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (nonstop_option),
        .q       (nonstop_s)
    );

    tick_divider #(
        .DIVIDE (TICK_DIVIDE)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    guard_state_type r_reg;
    guard_state_type r_next;

    localparam guard_state_type RESET_STATE = '{
        state:      BUS_IDLE,
        resp:       '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0},
        mode:       MODE_RESET_VALUE,
        write_done: 1'b0,
        stopped:    1'b0,
        pending:    1'b0,
        wdt_reset:  1'b0,
        count:      '0
    };

    logic setup;
    logic access;
    logic mapped;
    logic byte_wr;
    logic wr_mode;
    logic wr_restart;
    logic [2:0] sel;
    logic overflow;

    assign setup      = psel && !penable;
    assign access     = psel && penable && r_reg.resp.pready;
    assign mapped     = (paddr == OFF_MODE_CONFIG) || (paddr == OFF_RESTART) ||
                        (paddr == OFF_STATUS) || (paddr == OFF_COUNT);
    assign byte_wr    = (pstrb == STRB_BYTE0);
    assign wr_mode    = access && pwrite && (paddr == OFF_MODE_CONFIG);
    assign wr_restart = access && pwrite && (paddr == OFF_RESTART);
    assign sel        = r_reg.mode[MODE_SEL_MSB:0];
    assign overflow   = r_reg.count[OVF_BASE_BIT + int'(sel)];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;

        // Bus response: decided in the setup phase, registered for the access phase
        unique case (r_reg.state)
            BUS_IDLE: begin
                if (setup) begin
                    r_next.resp.pslverr = !mapped;
                    if (pwrite && paddr == OFF_MODE_CONFIG) begin
                        r_next.resp.pready = 1'b0;
                        r_next.state       = BUS_WAIT;
                    end else begin
                        r_next.resp.pready = 1'b1;
                    end
                    unique case (paddr)
                        OFF_MODE_CONFIG: r_next.resp.prdata = {24'h00_0000, r_reg.mode};
                        OFF_RESTART:     r_next.resp.prdata = {24'h00_0000, RESTART_READBACK};
                        OFF_STATUS: begin
                            r_next.resp.prdata                = 32'h0000_0000;
                            r_next.resp.prdata[ST_WRITE_DONE] = r_reg.write_done;
                            r_next.resp.prdata[ST_STOPPED]    = r_reg.stopped;
                            r_next.resp.prdata[ST_PENDING]    = r_reg.pending;
                            r_next.resp.prdata[ST_CLK_RUN]    = clk_run_s;
                            r_next.resp.prdata[ST_NONSTOP]    = nonstop_s;
                        end
                        OFF_COUNT: r_next.resp.prdata = {16'h0000, r_reg.count};
                        default:   r_next.resp.prdata = 32'h0000_0000;
                    endcase
                end else if (access) begin
                    r_next.resp.pready  = 1'b0;
                    r_next.resp.pslverr = 1'b0;
                end
            end
            BUS_WAIT: begin
                r_next.resp.pready = 1'b1;
                r_next.state       = BUS_IDLE;
            end
            default: begin
                r_next.resp.pready = 1'b0;
                r_next.state       = BUS_IDLE;
            end
        endcase

        // Watchdog counter, halted for good once stopped
        if (tick && clk_run_s && !r_reg.stopped && !r_reg.pending) begin
            r_next.count = r_reg.count + 1'b1;
        end
        if (clk_run_s && !r_reg.stopped && overflow) begin
            r_next.pending = 1'b1;
        end

        // Mode configuration writes
        if (wr_mode) begin
            if (r_reg.write_done) begin
                r_next.pending = 1'b1;
            end else if (byte_wr) begin
                r_next.write_done = 1'b1;
                r_next.mode       = pwdata[7:0];
                if (nonstop_s) begin
                    r_next.mode[MODE_UPPER_MSB:MODE_UPPER_LSB] = MODE_UPPER_FIXED;
                    r_next.mode[MODE_STOP_BIT] = 1'b0;
                end else if (pwdata[MODE_STOP_BIT]) begin
                    r_next.stopped = 1'b1;
                end
            end
        end

        // Restart register writes
        if (wr_restart) begin
            if (byte_wr && pwdata[7:0] == RESTART_KEY) begin
                r_next.count = '0;
            end else begin
                r_next.pending = 1'b1;
            end
        end

        // Reset raised only while the source clock runs
        if (r_reg.pending && clk_run_s) begin
            r_next.wdt_reset = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= RESET_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata    = r_reg.resp.prdata;
    assign pready    = r_reg.resp.pready;
    assign pslverr   = r_reg.resp.pslverr;
    assign wdt_reset = r_reg.wdt_reset;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_mode_wait: assert property (@(posedge pclk) disable iff (!presetn)
        setup && pwrite && paddr == OFF_MODE_CONFIG && r_reg.state == BUS_IDLE
        |=> !pready ##1 pready)
        else $error("mode write did not take one wait cycle");

    a_other_nowait: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !(pwrite && paddr == OFF_MODE_CONFIG) && r_reg.state == BUS_IDLE
        |=> pready)
        else $error("plain access was not answered at once");

    a_upper_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        nonstop_s && wr_mode && !r_reg.write_done && byte_wr
        |=> r_reg.mode[MODE_UPPER_MSB:MODE_UPPER_LSB] == MODE_UPPER_FIXED)
        else $error("upper mode bits not forced under non-stop option");

    a_second_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_mode && r_reg.write_done
        |=> r_reg.pending && $stable(r_reg.mode))
        else $error("second mode write not flagged or changed the mode");

    a_done_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.write_done |=> r_reg.write_done ##1 r_reg.write_done)
        else $error("write-done flag dropped without reset");

    a_reset_defer: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.pending && !clk_run_s && !wdt_reset |=> !wdt_reset)
        else $error("reset raised while source clock stopped");

    a_reset_resume: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.pending && clk_run_s |=> wdt_reset)
        else $error("pending reset not raised with clock running");

    a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.stopped && !wr_restart |=> r_reg.stopped && $stable(r_reg.count))
        else $error("stopped watchdog counted or restarted");

    a_stop_noreset: assert property (@(posedge pclk) disable iff (!presetn)
        wr_mode && !r_reg.write_done && byte_wr && !nonstop_s && pwdata[MODE_STOP_BIT]
        && !r_reg.pending |=> !r_reg.pending)
        else $error("stop select caused a reset");

    a_bad_key: assert property (@(posedge pclk) disable iff (!presetn)
        wr_restart && !(byte_wr && pwdata[7:0] == RESTART_KEY) |=> r_reg.pending)
        else $error("wrong restart value not flagged");

    a_restart_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == OFF_RESTART && r_reg.state == BUS_IDLE
        |=> prdata == {24'h00_0000, RESTART_READBACK})
        else $error("restart readback value wrong");

    // ------------------------------------------------------------
    // Bus response, mode write, restart, sticky flag, count and status assertions
    // ------------------------------------------------------------
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready stood longer than one cycle");

    a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr shown without pready");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped && r_reg.state == BUS_IDLE
        |=> pready && pslverr)
        else $error("unmapped access not refused");

    a_narrow_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        wr_mode && !r_reg.write_done && !byte_wr
        |=> !r_reg.write_done && $stable(r_reg.mode))
        else $error("narrow mode write was taken");

    a_first_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_mode && !r_reg.write_done && byte_wr
        |=> r_reg.write_done
            && r_reg.mode[MODE_SEL_MSB:0] == $past(pwdata[MODE_SEL_MSB:0]))
        else $error("first byte mode write not taken");

    a_nonstop_nostop: assert property (@(posedge pclk) disable iff (!presetn)
        nonstop_s && wr_mode && !r_reg.write_done && byte_wr
        |=> !r_reg.stopped && !r_reg.mode[MODE_STOP_BIT])
        else $error("stop select took effect under non-stop option");

    a_stop_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.stopped |=> r_reg.stopped)
        else $error("stopped flag dropped without reset");

    a_key_clears: assert property (@(posedge pclk) disable iff (!presetn)
        wr_restart && byte_wr && pwdata[7:0] == RESTART_KEY && !overflow && !r_reg.pending
        |=> r_reg.count == '0 && !r_reg.pending)
        else $error("restart key did not clear the count quietly");

    a_pending_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.pending |=> r_reg.pending)
        else $error("pending reset dropped without reset");

    a_reset_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_reset |=> wdt_reset)
        else $error("internal reset request dropped");

    a_count_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_run_s && !wr_restart |=> $stable(r_reg.count))
        else $error("count moved with source clock stopped");

    a_status_done: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == OFF_STATUS && r_reg.state == BUS_IDLE
        |=> prdata[ST_WRITE_DONE] == $past(r_reg.write_done))
        else $error("status write-done bit wrong");

endmodule : watchdog_mode_write_guard

// ---- hdl/wdt_guard_pkg.sv ----
// Package: register map, field layout and timing constants of the watchdog mode guard
package wdt_guard_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_MODE_CONFIG = 8'h00;
    localparam logic [7:0] OFF_RESTART     = 8'h04;
    localparam logic [7:0] OFF_STATUS      = 8'h08;
    localparam logic [7:0] OFF_COUNT       = 8'h0C;

    // ------------------------------------------------------------
    // Field layout and values
    // ------------------------------------------------------------
    localparam int         MODE_UPPER_MSB   = 7;
    localparam int         MODE_UPPER_LSB   = 5;
    localparam logic [2:0] MODE_UPPER_FIXED = 3'h3;
    localparam int         MODE_STOP_BIT    = 4;
    localparam int         MODE_SEL_MSB     = 2;
    localparam logic [7:0] MODE_RESET_VALUE = 8'h67;
    localparam logic [7:0] RESTART_KEY      = 8'hAC;
    localparam logic [7:0] RESTART_READBACK = 8'h9A;
    localparam logic [3:0] STRB_BYTE0       = 4'h1;

    // Status register bit positions
    localparam int ST_WRITE_DONE = 0;
    localparam int ST_STOPPED    = 1;
    localparam int ST_PENDING    = 2;
    localparam int ST_CLK_RUN    = 3;
    localparam int ST_NONSTOP    = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned PCLK_HZ      = 100_000_000;
    localparam int unsigned TICK_HZ      = 1_000_000;
    localparam int unsigned TICK_DIVIDE  = PCLK_HZ / TICK_HZ;
    localparam int          COUNT_WIDTH  = 16;
    localparam int          OVF_BASE_BIT = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01
    } bus_state_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_resp_type;

    typedef struct packed {
        bus_state_type          state;
        apb_resp_type           resp;
        logic [7:0]             mode;
        logic                   write_done;
        logic                   stopped;
        logic                   pending;
        logic                   wdt_reset;
        logic [COUNT_WIDTH-1:0] count;
    } guard_state_type;

endpackage : wdt_guard_pkg

// ---- hdl/level_sync.sv ----
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module level_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : level_sync

// ---- hdl/tick_divider.sv ----
// Divider giving a one-cycle enable pulse every DIVIDE clocks
`timescale 1ns/1ns
module tick_divider #(
    parameter int unsigned DIVIDE = 100
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    localparam int W = $clog2(DIVIDE);
    localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            tick    <= (cnt_reg == LAST);
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end
endmodule : tick_divider

// ---- verification/cpu_store_model.sv ----
// CPU side model issuing APB load and store transfers to the guard
`timescale 1ns/1ns
module cpu_store_model
    import wdt_guard_pkg::*;
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
    end

    // Stores drive the given data and strobes unchanged; loads drive a zero strobe
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        input logic [3:0] strb, output logic [31:0] rdata,
                        output logic err, output int waits);
        waits = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        pstrb   <= wr ? strb : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            waits++;
            @(posedge pclk);
        end
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cpu_store_model

// ---- verification/watchdog_mode_write_guard_test.sv ----
// Self-checking testbench of the watchdog mode write guard
`timescale 1ns/1ns
module watchdog_mode_write_guard_test;
    import wdt_guard_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, c1;
    logic [3:0]  pstrb;
    logic        src_clk_running, nonstop_option, wdt_reset, er;
    int          miscompares, num_checks, w;

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    watchdog_mode_write_guard dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_clk_running(src_clk_running), .nonstop_option(nonstop_option),
        .wdt_reset(wdt_reset));

    cpu_store_model cpu_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic wr(logic [7:0] addr, logic [31:0] data, logic [3:0] strb);
        cpu_u.xfer(1'b1, addr, data, strb, rd, er, w);
    endtask : wr

    task automatic rd_chk(string what, logic [7:0] addr, logic [31:0] exp);
        cpu_u.xfer(1'b0, addr, 32'h0, 4'h0, rd, er, w);
        compare(what, exp, rd);
    endtask : rd_chk

    task automatic do_reset(logic nonstop);
        @(posedge pclk);
        presetn         <= 1'b0;
        nonstop_option  <= nonstop;
        src_clk_running <= 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : do_reset

    task automatic wait_reset(int limit = 20);
        for (int i = 0; i < limit && wdt_reset !== 1'b1; i++) @(posedge pclk);
        compare("wdt_reset raised", 32'h1, {31'h0, wdt_reset});
    endtask : wait_reset

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0; src_clk_running = 1'b1; nonstop_option = 1'b0;
        miscompares = 0;
        num_checks  = 0;
        do_reset(1'b0);
        rd_chk("mode reset", OFF_MODE_CONFIG, 32'h67);
        rd_chk("restart readback", OFF_RESTART, 32'h9A);
        compare("read waits", 32'h0, 32'(w));
        rd_chk("status reset", OFF_STATUS, 32'h08);
        cpu_u.xfer(1'b0, 8'h10, 32'h0, 4'h0, rd, er, w);
        compare("unmapped err", 32'h1, {31'h0, er});
        compare("unmapped data", 32'h0, rd);
        $display("test reset_state done");

        wr(OFF_MODE_CONFIG, 32'h73, 4'h3);
        compare("wide write waits", 32'h1, 32'(w));
        rd_chk("mode after wide", OFF_MODE_CONFIG, 32'h67);
        wr(OFF_MODE_CONFIG, 32'h73, STRB_BYTE0);
        compare("byte write waits", 32'h1, 32'(w));
        rd_chk("mode written", OFF_MODE_CONFIG, 32'h73);
        rd_chk("status stopped", OFF_STATUS, 32'h0B);
        cpu_u.xfer(1'b0, OFF_COUNT, 32'h0, 4'h0, c1, er, w);
        repeat (300) @(posedge pclk);
        rd_chk("count frozen", OFF_COUNT, c1);
        compare("no stop reset", 32'h0, {31'h0, wdt_reset});
        $display("test single_write_stop done");

        src_clk_running <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(OFF_MODE_CONFIG, 32'h63, STRB_BYTE0);
        repeat (40) @(posedge pclk);
        compare("reset held off", 32'h0, {31'h0, wdt_reset});
        rd_chk("status pending", OFF_STATUS, 32'h07);
        rd_chk("mode kept", OFF_MODE_CONFIG, 32'h73);
        src_clk_running <= 1'b1;
        wait_reset();
        $display("test deferred_reset done");

        do_reset(1'b0);
        wr(OFF_MODE_CONFIG, 32'h63, STRB_BYTE0);
        wr(OFF_MODE_CONFIG, 32'h63, STRB_BYTE0);
        wait_reset();
        $display("test second_write done");

        do_reset(1'b1);
        wr(OFF_MODE_CONFIG, 32'hF3, STRB_BYTE0);
        rd_chk("mode forced", OFF_MODE_CONFIG, 32'h63);
        rd_chk("status nonstop", OFF_STATUS, 32'h19);
        cpu_u.xfer(1'b0, OFF_COUNT, 32'h0, 4'h0, c1, er, w);
        repeat (300) @(posedge pclk);
        cpu_u.xfer(1'b0, OFF_COUNT, 32'h0, 4'h0, rd, er, w);
        compare("count running", 32'h1, {31'h0, rd > c1});
        wr(OFF_RESTART, {24'h0, RESTART_KEY}, STRB_BYTE0);
        repeat (10) @(posedge pclk);
        compare("key no reset", 32'h0, {31'h0, wdt_reset});
        wr(OFF_RESTART, 32'h55, STRB_BYTE0);
        wait_reset();
        $display("test nonstop_restart done");

        // Select 0 overflows after 1 << OVF_BASE_BIT ticks counted from reset release
        do_reset(1'b0);
        wr(OFF_MODE_CONFIG, 32'h60, STRB_BYTE0);
        repeat (((1 << OVF_BASE_BIT) - 6) * TICK_DIVIDE) @(posedge pclk);
        compare("no early overflow", 32'h0, {31'h0, wdt_reset});
        wait_reset(1_000);
        $display("test overflow_reset done");
        complete_run();
    end

    initial begin
        #600_000;
        miscompares++;
        complete_run();
    end
endmodule : watchdog_mode_write_guard_test
